// ==== verilog/sleep_idle_power_control.sv ====
`timescale 1ns/100ps
// Functional notes
// - power-down opcode: Sleep, or Idle if selected
// - entering Sleep clears watchdog, may keep running
// - entry clears power-down flag, sets timeout flag
// - low, high and secondary oscillators keep running
// - system-clocked adc conversion abandoned in Sleep
// - ports hold their drive state in Sleep
// - non-watchdog resets behave same in Sleep
// - master clear, brownout, power-on: full reset
// - watchdog or interrupt wake resumes execution
// - next instruction prefetched during the opcode
// - enabled interrupt wakes, global enable ignored
// - global enable set: next instruction, then vector
// - watchdog cleared on every wake
// - interrupt other than clock switch already pending: opcode is a no-op
// - late interrupt: full entry then immediate wake
// - crystal mode waits 1024 oscillator periods
// - low-power regulator state during Sleep if selected
// - extra settle delay after low-power regulator Sleep
// - Idle halts cpu and flash, system clock runs
// - any enabled interrupt ends Idle, idle select kept
// - recover on irq ends doze at Idle wake
// - watchdog in Idle only wakes, doze unchanged
// - isr entry clears doze when recover on irq
`include "pwr_map.svh"

module sleep_idle_power_control #(
    parameter int IRQ_COUNT    = 8,
    parameter int CKSW_IRQ     = 1,
    parameter int OSC_WAIT_CYC = `OSC_START_CYC,
    parameter int REG_WAIT_CYC = `REG_SETTLE_CYC
) (
    // clock, reset, enable
    input  wire logic                 mclk_in,
    input  wire logic                 reset_in,
    input  wire logic                 clk_en_in,
    // register port
    input  wire pwr_pkg::bus_req_s    bus_in,
    output logic [7:0]                rd_data_out,
    // cpu pipeline and interrupt logic
    input  wire logic                 sleep_op_in,
    input  wire logic                 isr_entry_in,
    input  wire logic                 global_irq_enable_in,
    input  wire logic [IRQ_COUNT-1:0] irq_flag_in,
    input  wire logic [IRQ_COUNT-1:0] irq_enable_in,
    output logic                      prefetch_out,
    output logic                      resume_out,
    output logic                      vector_irq_out,
    output logic                      doze_active_out,
    // reset sources and watchdog
    input  wire logic                 master_clear_pin_reset_in,
    input  wire logic                 bor_reset_in,
    input  wire logic                 por_reset_in,
    input  wire logic                 wdt_timeout_in,
    output logic                      wdt_clear_out,
    output logic                      wdt_reset_out,
    output logic                      full_reset_out,
    output logic                      timeout_flag_n_out,
    output logic                      power_down_flag_n_out,
    // adc
    input  wire logic                 adc_busy_in,
    input  wire logic                 adc_dedicated_osc_in,
    output logic                      adc_abort_out,
    // clocks, ports, regulator
    output pwr_pkg::clk_ctl_s         clk_out,
    output logic                      port_hold_out,
    output logic                      reg_low_power_out
);
    import pwr_pkg::*;

    localparam logic [15:0] OSC_LOAD = 16'(OSC_WAIT_CYC - 1);
    localparam logic [15:0] REG_LOAD = 16'(REG_WAIT_CYC - 1);
    localparam logic [IRQ_COUNT-1:0] NO_CKSW =
        ~(IRQ_COUNT'(1) << CKSW_IRQ);

    localparam st_s ST_RST = '{
        state:             PS_RUN,
        cnt:               16'h0000,
        idle_select:       1'b0,
        doze_active:       1'b0,
        recover_on_irq:    1'b0,
        reg_lp_sel:        1'b0,
        xtal_mode:         1'b0,
        timeout_flag_n:    1'b1,
        power_down_flag_n: 1'b1,
        vec_pend:          1'b0,
        rd_data:           8'h00,
        clk:               7'h7f,
        wdt_clear:         1'b0,
        prefetch:          1'b0,
        resume:            1'b0,
        vector_irq:        1'b0,
        full_reset:        1'b0,
        wdt_reset:         1'b0,
        adc_abort:         1'b0,
        port_hold:         1'b0,
        reg_low_power:     1'b0
    };

    st_s  st_reg;
    st_s  st_next;
    logic irq_wake;
    logic irq_race;
    logic rst_src;
    logic entry_ok;

    // any interrupt with its own enable set, global enable not involved
    function automatic logic irq_any(
        input logic [IRQ_COUNT-1:0] flag,
        input logic [IRQ_COUNT-1:0] en,
        input logic [IRQ_COUNT-1:0] mask
    );
        irq_any = |(flag & en & mask);
    endfunction

    // wake uses every source, the opcode race ignores clock switch
    always_comb
    begin
        irq_wake = irq_any(irq_flag_in, irq_enable_in, {IRQ_COUNT{1'b1}});
        irq_race = irq_any(irq_flag_in, irq_enable_in, NO_CKSW);
        rst_src  = master_clear_pin_reset_in | bor_reset_in | por_reset_in;
        // opcode accepted this edge, used by the entry checks
        entry_ok = clk_en_in && !rst_src && st_reg.state == PS_RUN &&
                   sleep_op_in && !irq_race;
    end

    // next state of the whole block
    always_comb
    begin
        st_next            = st_reg;
        st_next.wdt_clear  = 1'b0;
        st_next.prefetch   = 1'b0;
        st_next.resume     = 1'b0;
        st_next.vector_irq = 1'b0;
        st_next.full_reset = 1'b0;
        st_next.wdt_reset  = 1'b0;
        st_next.adc_abort  = 1'b0;
        st_next.rd_data    = 8'h00;

        // register read, data stands the cycle after the strobe
        if (bus_in.rd)
        begin
            case (bus_in.addr)
                `CTRL_OFFSET:
                begin
                    st_next.rd_data[`CTRL_IDLE_BIT]  = st_reg.idle_select;
                    st_next.rd_data[`CTRL_DOZE_BIT]  = st_reg.doze_active;
                    st_next.rd_data[`CTRL_ROI_BIT]   = st_reg.recover_on_irq;
                    st_next.rd_data[`CTRL_REGLP_BIT] = st_reg.reg_lp_sel;
                    st_next.rd_data[`CTRL_XTAL_BIT]  = st_reg.xtal_mode;
                end
                `STATUS_OFFSET:
                begin
                    st_next.rd_data[`STAT_PD_BIT] = st_reg.power_down_flag_n;
                    st_next.rd_data[`STAT_TO_BIT] = st_reg.timeout_flag_n;
                    st_next.rd_data[`STAT_STATE_LSB +: 3] = st_reg.state;
                end
                default: st_next.rd_data = 8'h00;
            endcase
        end

        // control write; status flags are not writable here
        if (bus_in.wr && bus_in.addr == `CTRL_OFFSET)
        begin
            st_next.idle_select    = bus_in.wdata[`CTRL_IDLE_BIT];
            st_next.doze_active    = bus_in.wdata[`CTRL_DOZE_BIT];
            st_next.recover_on_irq = bus_in.wdata[`CTRL_ROI_BIT];
            st_next.reg_lp_sel     = bus_in.wdata[`CTRL_REGLP_BIT];
            st_next.xtal_mode      = bus_in.wdata[`CTRL_XTAL_BIT];
        end

        // hardware clear beats a software write in the same cycle
        if (isr_entry_in && st_reg.recover_on_irq)
            st_next.doze_active = 1'b0;

        case (st_reg.state)
            PS_RUN:
            begin
                if (sleep_op_in && !irq_race)
                begin
                    st_next.prefetch          = 1'b1;
                    st_next.wdt_clear         = 1'b1;
                    st_next.power_down_flag_n = 1'b0;
                    st_next.timeout_flag_n    = 1'b1;
                    if (st_reg.idle_select)
                        st_next.state = PS_IDLE;
                    else
                    begin
                        st_next.state = PS_SLEEP;
                        // only a conversion on the dedicated clock survives
                        st_next.adc_abort = adc_busy_in && !adc_dedicated_osc_in;
                    end
                end
                else if (!sleep_op_in && wdt_timeout_in)
                begin
                    st_next.wdt_reset      = 1'b1;
                    st_next.timeout_flag_n = 1'b0;
                end
                // a pending interrupt other than clock switch turns the opcode into a no-op
            end
            PS_IDLE:
            begin
                if (irq_wake)
                begin
                    st_next.state      = PS_RUN;
                    st_next.resume     = 1'b1;
                    st_next.wdt_clear  = 1'b1;
                    st_next.vector_irq = global_irq_enable_in;
                    if (st_reg.recover_on_irq)
                        st_next.doze_active = 1'b0;
                end
                else if (wdt_timeout_in)
                begin
                    // no reset and no doze change on this wake
                    st_next.state     = PS_RUN;
                    st_next.resume    = 1'b1;
                    st_next.wdt_clear = 1'b1;
                end
            end
            PS_SLEEP:
            begin
                // late interrupt lands here and wakes at once
                if (irq_wake || wdt_timeout_in)
                begin
                    st_next.wdt_clear = 1'b1;
                    st_next.vec_pend  = irq_wake && global_irq_enable_in;
                    if (st_reg.reg_lp_sel)
                    begin
                        st_next.state = PS_REG_WAIT;
                        st_next.cnt   = REG_LOAD;
                    end
                    else if (st_reg.xtal_mode)
                    begin
                        st_next.state = PS_OSC_WAIT;
                        st_next.cnt   = OSC_LOAD;
                    end
                    else
                    begin
                        st_next.state      = PS_RUN;
                        st_next.resume     = 1'b1;
                        st_next.vector_irq = irq_wake && global_irq_enable_in;
                    end
                end
            end
            PS_REG_WAIT:
            begin
                if (st_reg.cnt != 16'h0000)
                    st_next.cnt = st_reg.cnt - 16'h0001;
                else if (st_reg.xtal_mode)
                begin
                    st_next.state = PS_OSC_WAIT;
                    st_next.cnt   = OSC_LOAD;
                end
                else
                begin
                    st_next.state      = PS_RUN;
                    st_next.resume     = 1'b1;
                    st_next.vector_irq = st_reg.vec_pend;
                end
            end
            PS_OSC_WAIT:
            begin
                if (st_reg.cnt != 16'h0000)
                    st_next.cnt = st_reg.cnt - 16'h0001;
                else
                begin
                    st_next.state      = PS_RUN;
                    st_next.resume     = 1'b1;
                    st_next.vector_irq = st_reg.vec_pend;
                end
            end
            default: st_next.state = PS_RUN;
        endcase

        // same reset path asleep or awake, wakes by full reset
        if (rst_src)
        begin
            st_next            = ST_RST;
            st_next.full_reset = 1'b1;
        end

        // clock and pin controls follow the next state
        st_next.clk.cpu_clk_en = (st_next.state == PS_RUN);
        st_next.clk.flash_en   = (st_next.state == PS_RUN);
        st_next.clk.sys_clk_en = (st_next.state == PS_RUN) ||
                                 (st_next.state == PS_IDLE);
        st_next.clk.clock_output_pin_en  = st_next.clk.sys_clk_en;
        st_next.clk.lf_osc_en  = 1'b1;
        st_next.clk.hf_osc_en  = 1'b1;
        st_next.clk.sec_osc_en = 1'b1;
        st_next.port_hold      = (st_next.state == PS_SLEEP) ||
                                 (st_next.state == PS_REG_WAIT) ||
                                 (st_next.state == PS_OSC_WAIT);
        st_next.reg_low_power  = (st_next.state == PS_SLEEP) &&
                                 st_next.reg_lp_sel;
    end

    // single state register, frozen while the enable is low
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
            st_reg <= ST_RST;
        else if (clk_en_in)
            st_reg <= st_next;
    end

    // outputs straight from the state register
    assign rd_data_out           = st_reg.rd_data;
    assign prefetch_out          = st_reg.prefetch;
    assign resume_out            = st_reg.resume;
    assign vector_irq_out        = st_reg.vector_irq;
    assign doze_active_out       = st_reg.doze_active;
    assign wdt_clear_out         = st_reg.wdt_clear;
    assign wdt_reset_out         = st_reg.wdt_reset;
    assign full_reset_out        = st_reg.full_reset;
    assign timeout_flag_n_out    = st_reg.timeout_flag_n;
    assign power_down_flag_n_out = st_reg.power_down_flag_n;
    assign adc_abort_out         = st_reg.adc_abort;
    assign clk_out               = st_reg.clk;
    assign port_hold_out         = st_reg.port_hold;
    assign reg_low_power_out     = st_reg.reg_low_power;

    // checks
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    chk_idle_entry: assert property (
        entry_ok && st_reg.idle_select |=>
        st_reg.state == PS_IDLE && clk_out.sys_clk_en && !clk_out.cpu_clk_en)
        else $error("idle not entered");

    chk_sleep_entry: assert property (
        entry_ok && !st_reg.idle_select |=>
        st_reg.state == PS_SLEEP && !clk_out.sys_clk_en && !clk_out.cpu_clk_en)
        else $error("sleep not entered");

    chk_entry_flags: assert property (
        entry_ok |=> !power_down_flag_n_out && timeout_flag_n_out &&
        wdt_clear_out && prefetch_out)
        else $error("entry flags wrong");

    chk_nop_race: assert property (
        clk_en_in && !rst_src && st_reg.state == PS_RUN &&
        sleep_op_in && irq_race |=>
        $stable(power_down_flag_n_out) && $stable(timeout_flag_n_out) &&
        !wdt_clear_out && st_reg.state == PS_RUN)
        else $error("pending irq did not cancel opcode");

    chk_idle_wdt: assert property (
        clk_en_in && !rst_src && st_reg.state == PS_IDLE &&
        !irq_wake && wdt_timeout_in |=>
        resume_out && !wdt_reset_out && $stable(doze_active_out))
        else $error("watchdog in idle misbehaved");

    chk_full_reset: assert property (
        clk_en_in && rst_src |=> full_reset_out && st_reg.state == PS_RUN &&
        clk_out.cpu_clk_en)
        else $error("reset source did not reset");

    chk_sleep_wake: assert property (
        clk_en_in && !rst_src && st_reg.state == PS_SLEEP && irq_wake &&
        !st_reg.reg_lp_sel && !st_reg.xtal_mode |=>
        resume_out && wdt_clear_out && clk_out.cpu_clk_en &&
        vector_irq_out == $past(global_irq_enable_in))
        else $error("sleep wake wrong");

    chk_osc_wait: assert property (
        // checked per counted edge, so it holds for any wait length
        clk_en_in && !rst_src && st_reg.state == PS_OSC_WAIT &&
        st_reg.cnt != 16'h0000 |=>
        st_reg.state == PS_OSC_WAIT && !clk_out.cpu_clk_en && !resume_out)
        else $error("crystal start wait skipped");

    chk_reg_lp: assert property (
        st_reg.state != PS_SLEEP |-> !reg_low_power_out)
        else $error("regulator low power outside sleep");

    chk_osc_on: assert property (
        clk_out.lf_osc_en && clk_out.hf_osc_en && clk_out.sec_osc_en)
        else $error("sleep oscillator stopped");

    cov_idle_wake: cover property (
        st_reg.state == PS_IDLE ##1 resume_out);
    cov_xtal_wake: cover property (
        st_reg.state == PS_OSC_WAIT ##1 resume_out);
    cov_nop_race: cover property (
        st_reg.state == PS_RUN && sleep_op_in && irq_race && clk_en_in);

endmodule

// ==== include/pwr_map.svh ====
`ifndef PWR_MAP_SVH
`define PWR_MAP_SVH

// register offsets
`define CTRL_OFFSET 4'h0
`define STATUS_OFFSET 4'h4

// control register fields
`define CTRL_IDLE_BIT 0
`define CTRL_DOZE_BIT 1
`define CTRL_ROI_BIT 2
`define CTRL_REGLP_BIT 3
`define CTRL_XTAL_BIT 4

// status register fields
`define STAT_PD_BIT 0
`define STAT_TO_BIT 1
`define STAT_STATE_LSB 2

// timing
`define CLK_PERIOD_NS 40
`define OSC_START_PERIODS 1024
`define OSC_START_CYC `OSC_START_PERIODS
`define REG_SETTLE_US 10
`define REG_SETTLE_CYC ((`REG_SETTLE_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== include/pwr_pkg.sv ====
package pwr_pkg;

    typedef enum logic [2:0] {
        PS_RUN      = 3'b000,
        PS_IDLE     = 3'b001,
        PS_SLEEP    = 3'b010,
        PS_REG_WAIT = 3'b011,
        PS_OSC_WAIT = 3'b100
    } pwr_state_e;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_s;

    typedef struct packed {
        logic cpu_clk_en;
        logic flash_en;
        logic sys_clk_en;
        logic clock_output_pin_en;
        logic lf_osc_en;
        logic hf_osc_en;
        logic sec_osc_en;
    } clk_ctl_s;

    typedef struct packed {
        pwr_state_e  state;
        logic [15:0] cnt;
        logic        idle_select;
        logic        doze_active;
        logic        recover_on_irq;
        logic        reg_lp_sel;
        logic        xtal_mode;
        logic        timeout_flag_n;
        logic        power_down_flag_n;
        logic        vec_pend;
        logic [7:0]  rd_data;
        clk_ctl_s    clk;
        logic        wdt_clear;
        logic        prefetch;
        logic        resume;
        logic        vector_irq;
        logic        full_reset;
        logic        wdt_reset;
        logic        adc_abort;
        logic        port_hold;
        logic        reg_low_power;
    } st_s;

endpackage

// ==== tb/cpu_irq_model.sv ====
`timescale 1ns/100ps
// cpu pipeline and interrupt controller stand-in: holds the per-source
// flags and enters the isr one cycle after the block asks to vector
module cpu_irq_model (
    // clock and reset
    input  wire logic       mclk_in,
    input  wire logic       reset_in,
    // stimulus from the bench
    input  wire logic [7:0] raise_in,
    input  wire logic       clear_in,
    // answers from the power block
    input  wire logic       resume_in,
    input  wire logic       vector_irq_in,
    // towards the power block
    output logic [7:0]      irq_flag_out,
    output logic            isr_entry_out
);
    // flags drop once the cpu resumes, as the handler or the next
    // instructions would clear them; a wake never sees a stale flag
    always_ff @(posedge mclk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            irq_flag_out  <= 8'h00;
            isr_entry_out <= 1'b0;
        end
        else
        begin
            irq_flag_out  <= ((clear_in || resume_in) ? 8'h00 : irq_flag_out) | raise_in;
            isr_entry_out <= vector_irq_in;
        end
    end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
`include "pwr_map.svh"
module tb_top;
    import pwr_pkg::*;
    logic mclk_in = 1'b0, reset_in = 1'b1, slp = 1'b0, global_irq_enable = 1'b0, wdt = 1'b0;
    logic master_clear_pin = 1'b0, bor = 1'b0, por = 1'b0, busy = 1'b0, ded = 1'b0, clr = 1'b0, en = 1'b1;
    logic [7:0] rs = 8'h00, rdat, flags;
    bus_req_s bus = '0;
    logic [7:0] rd_data_out;
    logic prefetch_out, resume_out, vector_irq_out, doze_active_out, isr_entry;
    logic wdt_clear_out, wdt_reset_out, full_reset_out, timeout_flag_n_out;
    logic power_down_flag_n_out, adc_abort_out, port_hold_out, reg_low_power_out, v;
    clk_ctl_s clk_out;
    int n_errors = 0, checked = 0, cyc = 0, n;
    int n_pref = 0, n_wclr = 0, n_abort = 0, n_wrst = 0, n_frst = 0, i;

    sleep_idle_power_control #(.OSC_WAIT_CYC(4), .REG_WAIT_CYC(3)) sleep_idle_power_control_inst (
        .mclk_in(mclk_in), .reset_in(reset_in), .clk_en_in(en), .bus_in(bus),
        .rd_data_out(rd_data_out), .sleep_op_in(slp), .isr_entry_in(isr_entry),
        .global_irq_enable_in(global_irq_enable), .irq_flag_in(flags), .irq_enable_in(8'hff),
        .prefetch_out(prefetch_out), .resume_out(resume_out), .vector_irq_out(vector_irq_out),
        .doze_active_out(doze_active_out), .master_clear_pin_reset_in(master_clear_pin), .bor_reset_in(bor),
        .por_reset_in(por), .wdt_timeout_in(wdt), .wdt_clear_out(wdt_clear_out),
        .wdt_reset_out(wdt_reset_out), .full_reset_out(full_reset_out),
        .timeout_flag_n_out(timeout_flag_n_out), .power_down_flag_n_out(power_down_flag_n_out),
        .adc_busy_in(busy), .adc_dedicated_osc_in(ded), .adc_abort_out(adc_abort_out),
        .clk_out(clk_out), .port_hold_out(port_hold_out), .reg_low_power_out(reg_low_power_out));

    cpu_irq_model cpu_irq_model_inst (
        .mclk_in(mclk_in), .reset_in(reset_in), .raise_in(rs), .clear_in(clr),
        .resume_in(resume_out), .vector_irq_in(vector_irq_out),
        .irq_flag_out(flags), .isr_entry_out(isr_entry));

    always #20 mclk_in = ~mclk_in;

    // pulse tallies and hang guard; a pulse is counted at the edge that ends
    // it, so a tally is read one edge later; the ceiling is far above the run
    always @(posedge mclk_in)
    begin
        n_pref  += (prefetch_out === 1'b1);
        n_wclr  += (wdt_clear_out === 1'b1);
        n_abort += (adc_abort_out === 1'b1);
        n_wrst  += (wdt_reset_out === 1'b1);
        n_frst  += (full_reset_out === 1'b1);
        cyc++;
        if (cyc == 5000)
        begin
            n_errors++;
            give_verdict();
        end
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk_in) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk_in) bus <= '0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk_in) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk_in) bus <= '0;
        #1 d = rd_data_out;
    endtask

    task automatic status(input logic [7:0] exp);
        rd(`STATUS_OFFSET, rdat);
        chk(rdat, exp);
    endtask

    task automatic sleep_op();
        @(posedge mclk_in) slp <= 1'b1;
        @(posedge mclk_in) slp <= 1'b0;
        #1;
    endtask

    // wake stimulus, then edges until the resume pulse; irq costs one
    // extra edge through the flag register of the model
    task automatic kick(input logic [7:0] m, input logic w);
        @(posedge mclk_in)
        begin
            rs  <= m;
            wdt <= w;
            slp <= 1'b0; // ends an opcode strobe held by the caller
        end
        n = 0;
        v = 1'b0;
        repeat (40)
        begin
            @(posedge mclk_in)
            begin
                rs  <= 8'h00;
                wdt <= 1'b0;
            end
            #1 n++;
            if (resume_out === 1'b1)
            begin
                v = vector_irq_out;
                break;
            end
        end
    endtask

    task automatic tend(input string s);
        $display("test %s finished", s);
    endtask

    initial
    begin
        repeat (4) @(posedge mclk_in);
        reset_in <= 1'b0;
        status(8'h03);
        rd(`CTRL_OFFSET, rdat);
        chk(rdat, 8'h00);
        rd(4'h8, rdat);
        chk(rdat, 8'h00);
        wr(`STATUS_OFFSET, 8'h00);
        status(8'h03);
        chk({1'b0, clk_out}, 8'h7f);
        tend("reset");

        // idle, irq wake with global enable, recover on irq with doze
        wr(`CTRL_OFFSET, 8'h07);
        global_irq_enable <= 1'b1;
        sleep_op();
        chk({clk_out.cpu_clk_en, clk_out.flash_en, clk_out.sys_clk_en, clk_out.clock_output_pin_en}, 8'h03);
        status(8'h06);
        chk(8'(n_pref + n_wclr), 8'h02);
        kick(8'h08, 1'b0);
        chk(8'(n), 8'h02);
        chk(v, 1'b1);
        rd(`CTRL_OFFSET, rdat);
        chk(rdat, 8'h05);
        chk(8'(n_wclr), 8'h02);
        chk(doze_active_out, 1'b0);
        tend("idle_irq");

        // idle, watchdog wake: no reset, no vector, doze kept
        wr(`CTRL_OFFSET, 8'h03);
        global_irq_enable <= 1'b0;
        sleep_op();
        kick(8'h00, 1'b1);
        chk(8'(n), 8'h01);
        chk(v, 1'b0);
        chk(8'(n_wrst), 8'h00);
        chk(doze_active_out, 1'b1);
        tend("idle_wdt");

        // watchdog in run, then pending irq makes the opcode a no-op
        wr(`CTRL_OFFSET, 8'h00);
        @(posedge mclk_in) wdt <= 1'b1;
        @(posedge mclk_in) wdt <= 1'b0;
        status(8'h00);
        chk(8'(n_wrst), 8'h01);
        @(posedge mclk_in) rs <= 8'h20;
        @(posedge mclk_in) rs <= 8'h00;
        n_pref = 0;
        n_wclr = 0;
        sleep_op();
        status(8'h00);
        chk(8'(n_pref + n_wclr), 8'h00);
        @(posedge mclk_in) clr <= 1'b1;
        @(posedge mclk_in) clr <= 1'b0;
        // late interrupt: opcode completes, immediate wake
        @(posedge mclk_in)
        begin
            slp <= 1'b1;
            rs  <= 8'h40;
        end
        kick(8'h00, 1'b0);
        chk(resume_out, 1'b1);
        status(8'h02);
        chk(8'(n_wclr), 8'h02);
        tend("race");

        // sleep with low-power regulator and crystal, system-clocked adc
        wr(`CTRL_OFFSET, 8'h18);
        busy <= 1'b1;
        n_abort = 0;
        sleep_op();
        chk({clk_out.cpu_clk_en, clk_out.sys_clk_en, clk_out.clock_output_pin_en}, 8'h00);
        chk({clk_out.lf_osc_en, clk_out.hf_osc_en, clk_out.sec_osc_en}, 8'h07);
        chk({port_hold_out, reg_low_power_out}, 8'h03);
        status(8'h0a);
        chk(8'(n_abort), 8'h01);
        kick(8'h01, 1'b0);
        chk(8'(n), 8'(2 + 3 + 4));
        chk(v, 1'b0);
        @(posedge mclk_in) #1;
        chk({port_hold_out, reg_low_power_out}, 8'h00);
        // clock-switch flag pending does not block sleep; dedicated adc runs on
        wr(`CTRL_OFFSET, 8'h00);
        ded <= 1'b1;
        @(posedge mclk_in) rs <= 8'h02;
        @(posedge mclk_in) rs <= 8'h00;
        sleep_op();
        chk({port_hold_out, power_down_flag_n_out}, 8'h02);
        // the clock-switch flag is enabled, so it wakes at the next edge
        @(posedge mclk_in) #1;
        chk(resume_out, 1'b1);
        // watchdog wake from plain sleep, no wait states
        sleep_op();
        status(8'h0a);
        chk(8'(n_abort), 8'h01);
        kick(8'h00, 1'b1);
        chk(8'(n), 8'h01);
        busy <= 1'b0;
        tend("sleep");

        // each hardware reset source from sleep gives a full reset
        for (i = 0; i < 3; i++)
        begin
            n_frst = 0;
            sleep_op();
            @(posedge mclk_in)
            begin
                master_clear_pin <= (i == 0);
                bor  <= (i == 1);
                por  <= (i == 2);
            end
            @(posedge mclk_in) {master_clear_pin, bor, por} <= 3'b000;
            @(posedge mclk_in) #1;
            chk(8'(n_frst), 8'h01);
            status(8'h03);
        end
        tend("resets");

        // sleep irq wake with global enable and doze but no recover on irq
        wr(`CTRL_OFFSET, 8'h02);
        global_irq_enable <= 1'b1;
        sleep_op();
        kick(8'h10, 1'b0);
        chk(v, 1'b1);
        repeat (3) @(posedge mclk_in);
        #1 chk(doze_active_out, 1'b1);
        tend("isr_doze");
        // enable low freezes everything, a watchdog expiry included
        @(posedge mclk_in)
        begin
            en  <= 1'b0;
            wdt <= 1'b1;
        end
        repeat (2) @(posedge mclk_in);
        en  <= 1'b1;
        wdt <= 1'b0;
        status(8'h02);
        chk(8'(n_wrst), 8'h01);
        tend("enable");
        give_verdict();
    end
endmodule
